//--- src/dwms_defs.vh
// Constants for the Doppler weighting, magnitude and running-sum block
`ifndef DWMS_DEFS_VH
`define DWMS_DEFS_VH

`define DWMS_DIV_RATIO 2'd3
`define DWMS_DIV_LAST 2'd2
`define DWMS_PROG_LEN 7'd80
`define DWMS_PROG_LAST 7'd79

`define DWMS_STEP_MAG_F0 7'h20
`define DWMS_STEP_MAG_F1 7'h43
`define DWMS_STEP_MAG_F2 7'h4A
`define DWMS_STEP_MAG_F3 7'h01
`define DWMS_STEP_MAG_F4 7'h09
`define DWMS_STEP_MAG_F5 7'h11
`define DWMS_STEP_MAG_F6 7'h18
`define DWMS_STEP_MAG_F7 7'h27
`define DWMS_STEP_ZVF1 7'h2E
`define DWMS_STEP_ZVF2 7'h1B

`define DWMS_STEP_WT_0 7'h28
`define DWMS_STEP_WT_1 7'h33
`define DWMS_STEP_WT_2 7'h3C
`define DWMS_STEP_WT_3 7'h46
`define DWMS_STEP_WT_4 7'h4B
`define DWMS_STEP_WT_5 7'h02
`define DWMS_STEP_WT_6 7'h0C
`define DWMS_STEP_WT_7 7'h12
`define DWMS_STEP_WT_8 7'h19

`define DWMS_WT_INPUTS 4'd9
`define DWMS_WT_FIRST_VALID 4'd3

`define DWMS_ACT_WT 0
`define DWMS_ACT_MAG 1
`define DWMS_ACT_ZS1 2
`define DWMS_ACT_ZS2 3
`define DWMS_ACT_ZOUT 4

`define DWMS_DATA_W 16
`define DWMS_SUM_W 20
`define DWMS_NFILT 8
`define DWMS_DL_DEPTH 128
`define DWMS_FIFO_DEPTH 32

`endif

//--- src/dwms_fifo.v
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module dwms_fifo #(
    parameter WIDTH = 36,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire clock,
    input wire reset_n,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_r;
    reg [AW-1:0] rd_ptr_r;
    reg [AW:0] count_r;
    wire push;
    wire pop;

    assign in_ready = (count_r != DEPTH[AW:0]);
    assign out_valid = (count_r != {(AW+1){1'b0}});
    assign out_data = mem_r[rd_ptr_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage needs no reset; only pointers and count define what is valid
    always @(posedge clock)
    begin
        if (push)
        begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    always @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
            end
            if (push && !pop)
            begin
                count_r <= count_r + 1'b1;
            end
            else if (pop && !push)
            begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

//--- src/dwms_top.v
// Doppler weighting, magnitude forming and running filter sums
// Operation
// (R1) Table sequencer walks 80 steps at clock/3
// (R2) Counter clears at gate start; advances on data
// (R3) Magnitude transfers at steps 43, 4A, 27
// (R4) Zero-velocity halves handed over at 2E, 1B
// (R5) Nine weighting inputs: filters 0-7, then 0
// (R6) Output is middle minus quarter of neighbours
// (R7) First two weighted outputs of gate invalid
// (R8) Quarter terms ones-complemented, no carry-in
// (R9) Two-way selector swaps in zero-velocity sums
// (R10) Abs value: ones complement when sign set
// (R11) Max of larger, 7/8 larger plus half smaller
// (R12) Nonzero filters pass adder adding zero
// (R13) First half held; second added, total registered
// (R14) Zero-velocity total inserted between six and seven
// (R15) Eight magnitudes loaded on successive load strobes
// (R16) 128-word 16-bit delay line of magnitudes
// (R17) Eight 20-bit circulating per-filter sums
// (R18) Sum out as base; add new, drop oldest
// (R19) Synchronous stages; reset clears sums and delay
`timescale 1ns/10ps
`default_nettype none
`include "dwms_defs.vh"
module dwms_top #(
    parameter DW = `DWMS_DATA_W,
    parameter SW = `DWMS_SUM_W,
    parameter DL_DEPTH = `DWMS_DL_DEPTH,
    parameter DL_AW = 7,
    parameter FIFO_DEPTH = `DWMS_FIFO_DEPTH,
    parameter FIFO_AW = 5
) (
    input wire clock,
    input wire reset_n,
    input wire gate_start,
    input wire mem_data_valid,
    input wire [DW-1:0] dft_i,
    input wire [DW-1:0] dft_q,
    input wire [DW-1:0] zvf_i,
    input wire [DW-1:0] zvf_q,
    output wire out_valid,
    input wire out_ready,
    output wire [DW-1:0] out_magnitude,
    output wire [SW-1:0] out_threshold_base,
    output wire zero_select_strobe,
    output wire magnitude_load_strobe,
    output wire weighted_valid,
    output reg [DW-1:0] mag_buffer_r,
    output wire stalled
);
    // Divider and sequencer state
    reg [1:0] div_r;
    reg [6:0] pc_r;
    reg [3:0] wt_count_r;
    wire div_tick;
    wire step_en;
    wire fifo_in_ready;
    wire [4:0] act;

    // Weighting pipeline
    reg [DW-1:0] tap_i_r [0:2];
    reg [DW-1:0] tap_q_r [0:2];
    reg [DW-1:0] wt_i_r;
    reg [DW-1:0] wt_q_r;
    reg wt_valid_r;
    wire [DW-1:0] wt_i_nxt;
    wire [DW-1:0] wt_q_nxt;

    // Magnituder
    reg [DW-1:0] zvf_hold_r;
    reg [DW-1:0] zvf_total_r;
    wire [DW-1:0] sel_i;
    wire [DW-1:0] sel_q;
    wire [DW-1:0] mag_raw;
    wire [DW-1:0] add_side;
    wire [DW-1:0] adder_out;
    wire [DW-1:0] mag_sel;

    // Running summer
    reg [DW-1:0] dl_r [0:DL_DEPTH-1];
    reg [DL_AW-1:0] dl_ptr_r;
    reg [SW-1:0] sum_r [0:`DWMS_NFILT-1];
    reg [2:0] sum_ptr_r;
    wire [DW-1:0] dl_oldest;
    wire [SW-1:0] sum_out;
    wire [SW-1:0] sum_nxt;
    wire [DW+SW-1:0] fifo_out;

    integer k;

    // Program table: one action word per step [R1]
    function [4:0] prog_word;
        input [6:0] step;
        begin
            prog_word = 5'h00;
            case (step)
                `DWMS_STEP_WT_0, `DWMS_STEP_WT_1, `DWMS_STEP_WT_2,
                `DWMS_STEP_WT_3, `DWMS_STEP_WT_4, `DWMS_STEP_WT_5,
                `DWMS_STEP_WT_6, `DWMS_STEP_WT_7, `DWMS_STEP_WT_8:
                    prog_word[`DWMS_ACT_WT] = 1'b1; // [R5]
                `DWMS_STEP_MAG_F1, `DWMS_STEP_MAG_F2, `DWMS_STEP_MAG_F3,
                `DWMS_STEP_MAG_F4, `DWMS_STEP_MAG_F5, `DWMS_STEP_MAG_F6,
                `DWMS_STEP_MAG_F7:
                    prog_word[`DWMS_ACT_MAG] = 1'b1; // [R3]
                `DWMS_STEP_MAG_F0:
                begin
                    prog_word[`DWMS_ACT_MAG] = 1'b1;
                    prog_word[`DWMS_ACT_ZOUT] = 1'b1; // [R14]
                end
                `DWMS_STEP_ZVF1:
                    prog_word[`DWMS_ACT_ZS1] = 1'b1; // [R4]
                `DWMS_STEP_ZVF2:
                    prog_word[`DWMS_ACT_ZS2] = 1'b1; // [R4]
                default:
                    prog_word = 5'h00;
            endcase
        end
    endfunction

    // Absolute value then larger/smaller approximation
    function [DW-1:0] magnitude;
        input [DW-1:0] vi;
        input [DW-1:0] vq;
        reg [DW-1:0] ai;
        reg [DW-1:0] aq;
        reg [DW-1:0] lg;
        reg [DW-1:0] sm;
        reg [DW:0] est;
        begin
            ai = vi[DW-1] ? ~vi : vi; // [R10]
            aq = vq[DW-1] ? ~vq : vq; // [R10]
            lg = (ai >= aq) ? ai : aq; // [R11]
            sm = (ai >= aq) ? aq : ai;
            est = {1'b0, lg} - {4'h0, lg[DW-1:3]} + {2'h0, sm[DW-1:1]}; // [R11]
            // Inputs are below half scale, so the estimate always fits DW bits
            magnitude = (est > {1'b0, lg}) ? est[DW-1:0] : lg; // [R11]
        end
    endfunction

    // All but the divider and FIFO read side run on the divided step enable; full FIFO stalls them
    assign div_tick = (div_r == `DWMS_DIV_LAST); // [R1]
    assign step_en = div_tick && mem_data_valid && fifo_in_ready && !gate_start; // [R2] [R19]
    assign stalled = div_tick && mem_data_valid && !fifo_in_ready;
    assign act = step_en ? prog_word(pc_r) : 5'h00;
    assign zero_select_strobe = act[`DWMS_ACT_ZS1] || act[`DWMS_ACT_ZS2];
    assign magnitude_load_strobe = act[`DWMS_ACT_MAG];
    assign weighted_valid = wt_valid_r;

    always @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            div_r <= 2'd0;
            pc_r <= 7'd0;
        end
        else
        begin
            div_r <= div_tick ? 2'd0 : div_r + 2'd1; // [R1]
            if (gate_start)
            begin
                pc_r <= 7'd0; // [R2]
            end
            else if (step_en)
            begin
                pc_r <= (pc_r == `DWMS_PROG_LAST) ? 7'd0 : pc_r + 7'd1; // [R1] [R2]
            end
        end
    end

    // Quarter terms via ones complement, no carry: each subtracts one lsb more than its quarter
    assign wt_i_nxt = tap_i_r[0] + ~{{2{dft_i[DW-1]}}, dft_i[DW-1:2]}
                      + ~{{2{tap_i_r[1][DW-1]}}, tap_i_r[1][DW-1:2]}; // [R6] [R8]
    assign wt_q_nxt = tap_q_r[0] + ~{{2{dft_q[DW-1]}}, dft_q[DW-1:2]}
                      + ~{{2{tap_q_r[1][DW-1]}}, tap_q_r[1][DW-1:2]}; // [R6] [R8]

    always @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (k = 0; k < 3; k = k + 1)
            begin
                tap_i_r[k] <= {DW{1'b0}};
                tap_q_r[k] <= {DW{1'b0}};
            end
            wt_i_r <= {DW{1'b0}};
            wt_q_r <= {DW{1'b0}};
            wt_valid_r <= 1'b0;
            wt_count_r <= 4'd0;
        end
        else if (gate_start)
        begin
            wt_count_r <= 4'd0;
            wt_valid_r <= 1'b0;
        end
        else if (act[`DWMS_ACT_WT])
        begin
            tap_i_r[0] <= dft_i; // [R5]
            tap_q_r[0] <= dft_q;
            tap_i_r[1] <= tap_i_r[0];
            tap_q_r[1] <= tap_q_r[0];
            tap_i_r[2] <= tap_i_r[1];
            tap_q_r[2] <= tap_q_r[1];
            wt_i_r <= wt_i_nxt; // [R6]
            wt_q_r <= wt_q_nxt;
            // A gate's nine inputs straddle the program wrap, so filter zero restarts the count
            if (pc_r == `DWMS_STEP_WT_0)
            begin
                wt_count_r <= 4'd1; // [R5]
                wt_valid_r <= 1'b0; // [R7]
            end
            else
            begin
                if (wt_count_r != `DWMS_WT_INPUTS)
                begin
                    wt_count_r <= wt_count_r + 4'd1;
                end
                // Two leading results lack a full window of three
                wt_valid_r <= (wt_count_r + 4'd1 >= `DWMS_WT_FIRST_VALID); // [R7]
            end
        end
    end

    // Input selector: zero-velocity sums replace filter zero
    assign sel_i = zero_select_strobe ? zvf_i : wt_i_r; // [R9]
    assign sel_q = zero_select_strobe ? zvf_q : wt_q_r; // [R9]
    assign mag_raw = magnitude(sel_i, sel_q);
    assign add_side = act[`DWMS_ACT_ZS2] ? zvf_hold_r : {DW{1'b0}}; // [R12] [R13]
    assign adder_out = mag_raw + add_side; // [R12]
    assign mag_sel = act[`DWMS_ACT_ZOUT] ? zvf_total_r : adder_out; // [R14]

    always @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            zvf_hold_r <= {DW{1'b0}};
            zvf_total_r <= {DW{1'b0}};
            mag_buffer_r <= {DW{1'b0}};
        end
        else
        begin
            if (act[`DWMS_ACT_ZS1])
            begin
                zvf_hold_r <= mag_raw; // [R13]
            end
            if (act[`DWMS_ACT_ZS2])
            begin
                zvf_total_r <= adder_out; // [R13]
            end
            if (magnitude_load_strobe)
            begin
                mag_buffer_r <= mag_sel; // [R15]
            end
        end
    end

    // Running summer: circular index stands in for a shifting line
    assign dl_oldest = dl_r[dl_ptr_r]; // [R16]
    assign sum_out = sum_r[sum_ptr_r]; // [R17]
    assign sum_nxt = sum_out + {{(SW-DW){1'b0}}, mag_sel} - {{(SW-DW){1'b0}}, dl_oldest}; // [R18]

    always @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (k = 0; k < DL_DEPTH; k = k + 1)
            begin
                dl_r[k] <= {DW{1'b0}}; // [R19]
            end
            for (k = 0; k < `DWMS_NFILT; k = k + 1)
            begin
                sum_r[k] <= {SW{1'b0}}; // [R19]
            end
            dl_ptr_r <= {DL_AW{1'b0}};
            sum_ptr_r <= 3'd0;
        end
        else if (magnitude_load_strobe)
        begin
            dl_r[dl_ptr_r] <= mag_sel; // [R16]
            dl_ptr_r <= (dl_ptr_r == DL_DEPTH[DL_AW-1:0] - 1'b1) ? {DL_AW{1'b0}} : dl_ptr_r + 1'b1;
            sum_r[sum_ptr_r] <= sum_nxt; // [R18]
            sum_ptr_r <= sum_ptr_r + 3'd1; // [R17]
        end
    end

    // Magnitude and its threshold base leave together through the FIFO
    dwms_fifo #(
        .WIDTH(DW + SW),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .clock(clock),
        .reset_n(reset_n),
        .in_valid(magnitude_load_strobe),
        .in_ready(fifo_in_ready),
        .in_data({sum_out, mag_sel}), // [R15] [R18]
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(fifo_out)
    );

    assign out_magnitude = fifo_out[DW-1:0];
    assign out_threshold_base = fifo_out[DW+SW-1:DW];
endmodule
`default_nettype wire

//--- tb/dwms_sink.sv
// Downstream threshold-side sink with optional stalls
`timescale 1ns/10ps
`default_nettype none
module dwms_sink (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic hold_all,
    output logic out_ready
);
    logic [1:0] ph_r;
    // Drops ready one cycle in four so the FIFO sees a slow reader
    always @(negedge clock or negedge reset_n)
    begin
        if (!reset_n)
            ph_r <= 2'h0;
        else
            ph_r <= ph_r + 2'h1;
    end
    assign out_ready = !hold_all && (ph_r != 2'h3);
endmodule
`default_nettype wire

//--- tb/dwms_top_sva.sv
// Port checker for the weighting, magnitude and summing block
`timescale 1ns/10ps
`default_nettype none
module dwms_top_chk #(
    parameter DW = 16,
    parameter SW = 20
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic gate_start,
    input wire logic mem_data_valid,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic [DW-1:0] out_magnitude,
    input wire logic [SW-1:0] out_threshold_base,
    input wire logic zero_select_strobe,
    input wire logic magnitude_load_strobe,
    input wire logic [DW-1:0] mag_buffer_r,
    input wire logic stalled
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    a_gate_quiet: assert property (gate_start |-> !magnitude_load_strobe && !zero_select_strobe)
        else $error("strobe during gate start");
    a_data_gate: assert property (!mem_data_valid |-> !magnitude_load_strobe && !zero_select_strobe)
        else $error("strobe without memory data");
    a_step_gap: assert property ((magnitude_load_strobe || zero_select_strobe) |=>
        !(magnitude_load_strobe || zero_select_strobe) [*2]) else $error("steps too close");
    a_strobe_excl: assert property (!(magnitude_load_strobe && zero_select_strobe))
        else $error("both strobes at once");
    a_stall_quiet: assert property (stalled |-> !magnitude_load_strobe && !zero_select_strobe)
        else $error("step taken while stalled");
    a_buf_hold: assert property (!magnitude_load_strobe |=> $stable(mag_buffer_r))
        else $error("buffer changed without load");
    a_push_seen: assert property (magnitude_load_strobe |=> out_valid)
        else $error("load not queued");
    a_head_hold: assert property (out_valid && !out_ready |=>
        out_valid && $stable(out_magnitude) && $stable(out_threshold_base)) else $error("head moved unpopped");
endmodule
bind dwms_top dwms_top_chk #(.DW(DW), .SW(SW)) u_chk (
    .clock(clock),
    .reset_n(reset_n),
    .gate_start(gate_start),
    .mem_data_valid(mem_data_valid),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_magnitude(out_magnitude),
    .out_threshold_base(out_threshold_base),
    .zero_select_strobe(zero_select_strobe),
    .magnitude_load_strobe(magnitude_load_strobe),
    .mag_buffer_r(mag_buffer_r),
    .stalled(stalled)
);
`default_nettype wire

//--- tb/dwms_top_bench.sv
// Self-checking bench for the weighting, magnitude and summing block
`timescale 1ns/10ps
`default_nettype none
module dwms_top_bench;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic gate_start = 1'b0;
    logic mem_data_valid = 1'b0;
    logic hold_all = 1'b0;
    logic [15:0] dft_i = 16'h0400;
    logic [15:0] dft_q = 16'hFC00;
    logic [15:0] zvf_i = 16'h0100;
    logic [15:0] zvf_q = 16'hFF00;
    wire out_valid, out_ready, zero_select_strobe, magnitude_load_strobe, weighted_valid, stalled;
    wire [15:0] out_magnitude;
    wire [15:0] mag_buffer_r;
    wire [19:0] out_threshold_base;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;
    int nword = 0;
    logic [35:0] got [0:255];
    localparam int MS_STEP [8] = '{1, 9, 17, 24, 32, 39, 67, 74};
    localparam int ZS_STEP [2] = '{27, 46};
    always #4 clock = ~clock;
    dwms_top dut (.clock(clock), .reset_n(reset_n), .gate_start(gate_start), .mem_data_valid(mem_data_valid),
        .dft_i(dft_i), .dft_q(dft_q), .zvf_i(zvf_i), .zvf_q(zvf_q), .out_valid(out_valid), .out_ready(out_ready),
        .out_magnitude(out_magnitude), .out_threshold_base(out_threshold_base),
        .zero_select_strobe(zero_select_strobe), .magnitude_load_strobe(magnitude_load_strobe),
        .weighted_valid(weighted_valid), .mag_buffer_r(mag_buffer_r), .stalled(stalled));
    dwms_sink sink (.clock(clock), .reset_n(reset_n), .hold_all(hold_all), .out_ready(out_ready));
    function automatic logic [15:0] absv(input logic [15:0] x);
        return x[15] ? ~x : x;
    endfunction
    // Quarter terms complemented with no carry-in, so a steady input loses two lsb
    function automatic logic [15:0] wt(input logic [15:0] x);
        logic [15:0] q4;
        q4 = ~{{2{x[15]}}, x[15:2]};
        return x + q4 + q4;
    endfunction
    function automatic logic [15:0] magf(input logic [15:0] i, input logic [15:0] q);
        logic [15:0] a, b, l, s, e;
        a = absv(i);
        b = absv(q);
        l = (a > b) ? a : b;
        s = (a > b) ? b : a;
        e = l - (l >> 3) + (s >> 1);
        return (e > l) ? e : l;
    endfunction
    task automatic chk(input logic [19:0] exp, input logic [19:0] act);
        cmp_count++;
        if (act !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, act);
        end
    endtask
    task automatic tally_and_finish();
        if (err_total == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Pops are sampled at the edge that takes them
    always @(posedge clock)
    begin
        if (out_valid === 1'b1 && out_ready === 1'b1 && nword < 256)
        begin
            got[nword] = {out_threshold_base, out_magnitude};
            nword++;
        end
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            tally_and_finish();
        end
    end
    task automatic t_backpressure();
        int n;
        wait (nword >= 16);
        @(negedge clock) mem_data_valid = 1'b0;
        repeat (9) @(negedge clock);
        mem_data_valid = 1'b1;
        hold_all = 1'b1;
        n = 0;
        while (stalled !== 1'b1 && n < 3000)
        begin
            @(negedge clock);
            n++;
        end
        chk(20'h1, 20'(stalled));
        n = nword;
        repeat (30) @(negedge clock);
        chk(20'(n), 20'(nword));
        hold_all = 1'b0;
    endtask
    // First gate reads unprimed pipeline state, so judging starts at the second
    task automatic t_stream();
        logic [15:0] m, z, e;
        int k;
        m = magf(wt(dft_i), wt(dft_q));
        z = magf(zvf_i, zvf_q);
        wait (nword >= 184);
        for (k = 8; k < 184; k++)
        begin
            e = (k % 8 == 4) ? z + z : m;
            chk({4'h0, e}, {4'h0, got[k][15:0]});
            if (k >= 136)
                chk({e, 4'h0}, got[k][35:16]);
        end
    endtask
    task automatic t_restart();
        int pos_ms [8];
        int pos_zs [2];
        logic wv_ms [8];
        logic wv_zs [2];
        logic [15:0] zb, ze;
        int nm, nz, t;
        nm = 0;
        nz = 0;
        ze = magf(zvf_i, zvf_q);
        @(negedge clock) gate_start = 1'b1;
        @(negedge clock) gate_start = 1'b0;
        for (t = 0; t < 245; t++)
        begin
            @(negedge clock);
            // Buffer shows the zero-velocity total one cycle after its load
            if (nm == 5 && t == pos_ms[4] + 1)
                zb = mag_buffer_r;
            if (magnitude_load_strobe === 1'b1 && nm < 8)
            begin
                pos_ms[nm] = t;
                wv_ms[nm] = weighted_valid;
                nm++;
            end
            if (zero_select_strobe === 1'b1 && nz < 2)
            begin
                pos_zs[nz] = t;
                wv_zs[nz] = weighted_valid;
                nz++;
            end
        end
        chk(20'(82), 20'(nm * 10 + nz));
        chk(20'h0, 20'(wv_zs[1]));
        chk(20'h1, 20'(wv_ms[6]));
        chk({4'h0, ze + ze}, {4'h0, zb});
        chk(20'(pos_ms[0] < 8), 20'h1);
        for (t = 1; t < 8; t++)
            chk(20'(pos_ms[t] - pos_ms[0]), 20'((MS_STEP[t] - 1) * 3));
        for (t = 0; t < 2; t++)
            chk(20'(pos_zs[t] - pos_ms[0]), 20'((ZS_STEP[t] - 1) * 3));
    endtask
    initial
    begin
        repeat (3) @(negedge clock);
        reset_n = 1'b1;
        @(negedge clock) gate_start = 1'b1;
        @(negedge clock) gate_start = 1'b0;
        mem_data_valid = 1'b1;
        t_backpressure();
        t_stream();
        t_restart();
        tally_and_finish();
    end
endmodule
`default_nettype wire
